// [design/flash_command_sequencer.sv]
// Flash array with AHB read port and APB program/erase sequencer
//
// Overview of operation
// - AHB serves fetches, APB drives program/erase
// - Plain AHB read returns one array word
// - Array is 80 pages, 8 rows, 64 words
// - Address splits into page, row, word
// - Programming only clears bits to zero
// - Code 0x11 erases addressed page to ones
// - Code 0x22 erases whole array to ones
// - Code 0x33 programs one loaded word
// - Code 0xCC programs four consecutive words
// - Started flag set when command begins
// - Writing one clears started flag
// - Done flag set at end, write-one clears
// - Command while busy raises error flag
// - Undefined code while idle raises illegal-command flag
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
`include "flash_seq_defs.svh"

module flash_command_sequencer #(
   parameter int ERASE_CYC = (`ERASE_NS + `CLK_NS - 1) / `CLK_NS
) (
   input  wire logic                 CLK,
   input  wire logic                 RESET,
   input  wire logic                 PSEL,
   input  wire logic                 PENABLE,
   input  wire logic                 PWRITE,
   input  wire logic [7:0]           PADDR,
   input  wire flash_seq_pkg::word_t PWDATA,
   output      flash_seq_pkg::word_t PRDATA,
   output      logic                 PREADY,
   output      logic                 PSLVERR,
   input  wire logic                 HSEL,
   input  wire logic [31:0]          HADDR,
   input  wire logic [1:0]           HTRANS,
   input  wire logic                 HWRITE,
   input  wire logic                 HREADY,
   output      flash_seq_pkg::word_t HRDATA,
   output      logic                 HREADYOUT,
   output      logic                 HRESP
);
   import flash_seq_pkg::*;

   localparam int WORD_CYC = (`WORD_NS + `CLK_NS - 1) / `CLK_NS;
   localparam int QUAD_CYC = (`QUAD_NS + `CLK_NS - 1) / `CLK_NS;

   function automatic logic [19:0] cyc(input int c);
      return c[19:0] - 20'h00001;
   endfunction

   function automatic logic in_range(input logic [15:0] a);
      return a < `ALL_WORDS;
   endfunction

   word_t          mem [0:40959];

   word_t          cmd_r;
   logic [15:0]    addr_r;
   word_t          dat_r [0:3];
   logic [5:0]     mask_r;
   logic [5:0]     raw_r;
   logic [5:0]     raw_nxt;
   state_t         seq_r;
   op_t            op_r;
   op_t            op_nxt;
   logic [19:0]    tmr_r;
   logic [19:0]    tmr_nxt;
   logic [15:0]    ptr_r;
   logic [1:0]     idx_r;
   logic [15:0]    cnt_r;
   word_t          prdata_r;
   logic           pend_r;
   logic [15:0]    haddr_r;
   word_t          hrdata_r;

   // APB decode
   wire            acc      = PSEL & PENABLE;
   wire            wr       = acc & PWRITE;
   wire            w_cmd    = wr && PADDR == `OFS_CMD;
   wire            w_clr    = wr && (PADDR == `OFS_STAT || PADDR == `OFS_RAW);
   wire            w_mask   = wr && PADDR == `OFS_MASK;
   wire            w_addr   = wr && PADDR == `OFS_ADDR;
   wire            dat_sel  = {PADDR[7:4], 4'h0} == `OFS_DAT0 && PADDR[1:0] == 2'h0;
   wire            w_dat    = wr && dat_sel;
   wire [7:0]      code     = PWDATA[7:0];
   wire            code_ok  = PWDATA[31:8] == 24'h000000 &&
                              (code == `CODE_PAGE || code == `CODE_MASS ||
                               code == `CODE_WORD || code == `CODE_QUAD);
   wire            busy     = seq_r != SEQ_IDLE;
   wire            go       = w_cmd & ~busy & code_ok;
   wire            bad_busy = w_cmd & busy;
   wire            bad_code = w_cmd & ~busy & ~code_ok;
   wire            fin      = seq_r == SEQ_EXEC && cnt_r == `ONE_WORD;
   wire [5:0]      clr      = w_clr ? PWDATA[5:0] : 6'h00;
   wire [5:0]      set      = {2'b00, bad_code, bad_busy, go, fin};
   wire            hit      = PADDR == `OFS_CMD  || PADDR == `OFS_STAT ||
                              PADDR == `OFS_MASK || PADDR == `OFS_RAW  ||
                              PADDR == `OFS_SIZE || PADDR == `OFS_ADDR ||
                              dat_sel;
   word_t          rd_mux;

   // done is cleared the same way
   assign raw_nxt = (raw_r & ~clr) | set;

   always_comb begin
      case (PADDR)
         `OFS_CMD:  rd_mux = cmd_r;
         `OFS_STAT: rd_mux = {26'h0000000, raw_r & mask_r};
         `OFS_MASK: rd_mux = {26'h0000000, mask_r};
         `OFS_RAW:  rd_mux = {26'h0000000, raw_r};
         `OFS_SIZE: rd_mux = `SIZE_VAL;
         `OFS_ADDR: rd_mux = {16'h0000, addr_r};
         `OFS_DAT0: rd_mux = dat_r[0];
         `OFS_DAT1: rd_mux = dat_r[1];
         `OFS_DAT2: rd_mux = dat_r[2];
         `OFS_DAT3: rd_mux = dat_r[3];
         default:   rd_mux = 32'h00000000;
      endcase
   end

   // Operation decode at acceptance
   always_comb begin
      op_nxt  = op_r;
      tmr_nxt = cyc(WORD_CYC);
      case (code)
         `CODE_PAGE: begin
            // page field, row and word forced zero
            op_nxt  = '{OP_PAGE, {addr_r[15:9], 9'h000}, `PAGE_WORDS};
            tmr_nxt = cyc(ERASE_CYC);
         end
         `CODE_MASS: begin
            op_nxt  = '{OP_MASS, 16'h0000, `ALL_WORDS};
            tmr_nxt = cyc(ERASE_CYC);
         end
         `CODE_WORD: begin
            op_nxt  = '{OP_WORD, addr_r, `ONE_WORD};
         end
         `CODE_QUAD: begin
            op_nxt  = '{OP_QUAD, addr_r, `QUAD_WORDS};
            tmr_nxt = cyc(QUAD_CYC);
         end
         default: begin
            op_nxt  = op_r;
         end
      endcase
   end

   wire            erase    = op_r.kind == OP_PAGE || op_r.kind == OP_MASS;
   wire            mem_we   = seq_r == SEQ_EXEC && in_range(ptr_r);
   wire word_t     mem_rd   = in_range(ptr_r) ? mem[ptr_r] : `ONES;
   wire word_t     mem_wd   = erase ? `ONES : mem_rd & dat_r[idx_r];

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         cmd_r    <= 32'h00000000;
         addr_r   <= 16'h0000;
         dat_r    <= '{default: `ONES};
         mask_r   <= `MASK_RST;
         raw_r    <= 6'h00;
         prdata_r <= 32'h00000000;
      end else begin
         raw_r <= raw_nxt;
         if (w_cmd)
            cmd_r <= PWDATA;
         if (w_mask)
            mask_r <= PWDATA[5:0];
         if (w_addr)
            addr_r <= PWDATA[15:0];
         if (w_dat)
            dat_r[PADDR[3:2]] <= PWDATA;
         if (PSEL & ~PENABLE)
            prdata_r <= rd_mux;
      end
   end

   // Sequencer: wait out the array time, then walk the words
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         seq_r <= SEQ_IDLE;
         op_r  <= '{OP_PAGE, 16'h0000, 16'h0000};
         tmr_r <= 20'h00000;
         ptr_r <= 16'h0000;
         idx_r <= 2'h0;
         cnt_r <= 16'h0000;
      end else begin
         case (seq_r)
            SEQ_IDLE: begin
               if (go) begin
                  seq_r <= SEQ_WAIT;
                  op_r  <= op_nxt;
                  tmr_r <= tmr_nxt;
                  ptr_r <= op_nxt.base;
                  cnt_r <= op_nxt.count;
                  idx_r <= 2'h0;
               end
            end
            SEQ_WAIT: begin
               if (tmr_r == 20'h00000)
                  seq_r <= SEQ_EXEC;
               else
                  tmr_r <= tmr_r - 20'h00001;
            end
            SEQ_EXEC: begin
               ptr_r <= ptr_r + 16'h0001;
               idx_r <= idx_r + 2'h1;
               cnt_r <= cnt_r - 16'h0001;
               if (fin)
                  seq_r <= SEQ_IDLE;
            end
            default: begin
               seq_r <= SEQ_IDLE;
            end
         endcase
      end
   end

   // Array contents have no reset, as in a real flash
   always_ff @(posedge CLK) begin
      if (mem_we)
         mem[ptr_r] <= mem_wd;
   end

   // AHB read port, writes answered OKAY and dropped
   wire            h_take   = HSEL & HREADY & HTRANS[1] & ~HWRITE;

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         pend_r   <= 1'b0;
         haddr_r  <= 16'h0000;
         hrdata_r <= 32'h00000000;
      end else begin
         if (h_take) begin
            pend_r  <= 1'b1;
            haddr_r <= HADDR[17:2];
         // hold the read until the array is idle
         end else if (pend_r & ~busy) begin
            pend_r   <= 1'b0;
            hrdata_r <= in_range(haddr_r) ? mem[haddr_r] : 32'h00000000;
         end
      end
   end

   assign PRDATA    = prdata_r;
   assign PREADY    = 1'b1;
   assign PSLVERR   = acc & ~hit;
   assign HRDATA    = hrdata_r;
   assign HREADYOUT = ~pend_r;
   assign HRESP     = 1'b0;

   default clocking @(posedge CLK);
   endclocking
   default disable iff (RESET);

   sequence s_word_go;
      go && code == `CODE_WORD;
   endsequence

   sequence s_waiting;
      (seq_r == SEQ_WAIT && busy)[*8];
   endsequence

   start_flag_a: assert property (go |=> raw_r[`B_START] && busy)
      else $error("started flag not set on accept");
   start_clear_a: assert property (w_clr && PWDATA[`B_START] |=> !raw_r[`B_START])
      else $error("started flag survived write-one clear");
   done_flag_a: assert property (fin |=> raw_r[`B_DONE] && seq_r == SEQ_IDLE)
      else $error("done flag missing at end");
   busy_err_a: assert property (bad_busy |=> raw_r[`B_ERR] && $stable(op_r))
      else $error("busy command not flagged");
   ill_code_a: assert property (bad_code |=> raw_r[`B_ILL] && seq_r == SEQ_IDLE)
      else $error("illegal code not flagged");
   word_wait_a: assert property (s_word_go |=> s_waiting)
      else $error("program wait too short");
   page_base_a: assert property (go && code == `CODE_PAGE
                                 |=> op_r.base[8:0] == 9'h000 && cnt_r == `PAGE_WORDS)
      else $error("page erase base or size wrong");
   clear_only_a: assert property (mem_we && !erase
                                  |=> (mem[$past(ptr_r)] & ~$past(mem_rd)) == 32'h00000000)
      else $error("program would set a bit");
   erase_ones_a: assert property (mem_we && erase |=> mem[$past(ptr_r)] == `ONES)
      else $error("erase not all ones");
   read_stall_a: assert property (pend_r && busy |=> !HREADYOUT)
      else $error("array read finished during operation");
endmodule

// [design/flash_seq_defs.svh]
// Offsets, codes, bit positions and times of the flash command sequencer
`ifndef FLASH_SEQ_DEFS_SVH
`define FLASH_SEQ_DEFS_SVH
`define OFS_CMD    8'h00
`define OFS_STAT   8'h08
`define OFS_MASK   8'h0C
`define OFS_RAW    8'h10
`define OFS_SIZE   8'h14
`define OFS_ADDR   8'h18
`define OFS_DAT0   8'h40
`define OFS_DAT1   8'h44
`define OFS_DAT2   8'h48
`define OFS_DAT3   8'h4C
`define CODE_PAGE  8'h11
`define CODE_MASS  8'h22
`define CODE_WORD  8'h33
`define CODE_QUAD  8'hCC
`define B_DONE     0
`define B_START    1
`define B_ERR      2
`define B_ILL      3
`define MASK_RST   6'h3F
`define SIZE_VAL   32'h00009FFF
`define ONES       32'hFFFFFFFF
`define PAGE_WORDS 16'h0200
`define ALL_WORDS  16'hA000
`define QUAD_WORDS 16'h0004
`define ONE_WORD   16'h0001
`define ERASE_NS   21500000
`define WORD_NS    44000
`define QUAD_NS    107000
`define CLK_NS     50
`endif

// [design/flash_seq_pkg.sv]
// Types shared by the flash command sequencer
package flash_seq_pkg;
   typedef logic [31:0] word_t;
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_WAIT = 2'b01,
      SEQ_EXEC = 2'b10
   } state_t;
   typedef enum logic [1:0] {
      OP_PAGE = 2'b00,
      OP_MASS = 2'b01,
      OP_WORD = 2'b10,
      OP_QUAD = 2'b11
   } op_kind_t;
   typedef struct packed {
      op_kind_t    kind;
      logic [15:0] base;
      logic [15:0] count;
   } op_t;
endpackage

// [sim/fcs_host.sv]
// AHB fetch master standing in for the processor
`timescale 1ns/1ps
module fcs_host
   import flash_seq_pkg::*;
(
   input  wire logic                 CLK,
   input  wire flash_seq_pkg::word_t HRDATA,
   input  wire logic                 HREADYOUT,
   output      logic                 HSEL,
   output      logic [31:0]          HADDR,
   output      logic [1:0]           HTRANS,
   output      logic                 HREADY
);
   logic [31:0] a_q    = 32'h0;
   logic [31:0] idle_q = 32'h0;
   assign HREADY = HREADYOUT;
   // Idle address is idle_q, which stays zero since the negation of zero is zero
   assign HADDR = HSEL ? a_q : idle_q;
   always @(posedge CLK) idle_q <= ~idle_q + 32'h1;
   initial HSEL = 1'b0;
   initial HTRANS = 2'b00;
   task automatic fetch(input logic [15:0] w, input int gap, output word_t d);
      repeat (gap + 1) @(posedge CLK);
      HSEL <= 1'b1;
      HTRANS <= 2'b10;
      a_q <= {14'h0, w, 2'b00};
      @(posedge CLK);
      while (HREADYOUT !== 1'b1) @(posedge CLK);
      HSEL <= 1'b0;
      HTRANS <= 2'b00;
      @(posedge CLK);
      while (HREADYOUT !== 1'b1) @(posedge CLK);
      d = HRDATA;
   endtask
endmodule

// [sim/flash_command_sequencer_tb_top.sv]
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`include "flash_seq_defs.svh"
module flash_command_sequencer_tb_top;
   import flash_seq_pkg::*;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        hwrite = 1'b0;
   logic [7:0]  paddr = 8'h0;
   word_t       pwdata = 32'h0;
   word_t       prdata, hrdata, v, d;
   logic        pready, pslverr, hsel, hready, hreadyout, hresp, slv;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   int          err_count = 0;
   int          comparisons = 0;
   int          w;
   word_t       em [int];
   logic [7:0]  ro [9] = '{`OFS_CMD, `OFS_MASK, `OFS_RAW, `OFS_SIZE, `OFS_ADDR,
                           `OFS_DAT0, `OFS_DAT1, `OFS_DAT2, `OFS_DAT3};
   word_t       rv [9] = '{32'h0, 32'h3F, 32'h0, `SIZE_VAL, 32'h0,
                           `ONES, `ONES, `ONES, `ONES};
   always #25 clk = ~clk;
   // Short erase wait keeps the run brief
   flash_command_sequencer #(.ERASE_CYC(20)) DUT (.CLK(clk), .RESET(reset), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp));
   fcs_host host (.CLK(clk), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htrans), .HREADY(hready));
   // Unwritten model words read as erased
   function automatic word_t ev(int i);
      return em.exists(i) ? em[i] : `ONES;
   endfunction
   task automatic check(word_t s, word_t e, string m);
      comparisons++;
      if (s !== e) begin
         err_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, s, e);
      end
   endtask
   task automatic finish_test();
      $display("mismatches %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic apb(bit wr, logic [7:0] a, word_t wd);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      v = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_bit(logic [7:0] a, int b);
      do apb(1'b0, a, 32'h0); while (v[b] !== 1'b1);
   endtask
   task automatic run(logic [7:0] code);
      apb(1'b1, `OFS_CMD, {24'h0, code});
      wait_bit(`OFS_STAT, `B_START);
      apb(1'b1, `OFS_STAT, 32'h2);
      apb(1'b0, `OFS_RAW, 32'h0);
      check(v & 32'h2, 32'h0, "start clear");
      wait_bit(`OFS_STAT, `B_DONE);
      apb(1'b1, `OFS_STAT, 32'h1);
      apb(1'b0, `OFS_RAW, 32'h0);
      check(v, 32'h0, "done clear");
   endtask
   task automatic prog(int i, word_t x);
      apb(1'b1, `OFS_ADDR, i);
      apb(1'b1, `OFS_DAT0, x);
      run(`CODE_WORD);
      em[i] = ev(i) & x;
   endtask
   task automatic rd(int i);
      host.fetch(i[15:0], $urandom % 3, d);
      check(d, ev(i), "array word");
      check({31'h0, hresp}, 32'h0, "resp");
   endtask
   initial begin
      void'($urandom(76688));
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      foreach (ro[i]) begin
         apb(1'b0, ro[i], 32'h0);
         check(v, rv[i], "reset value");
         check({31'h0, slv}, 32'h0, "mapped slverr");
      end
      apb(1'b1, `OFS_SIZE, 32'h0);
      apb(1'b0, `OFS_SIZE, 32'h0);
      check(v, `SIZE_VAL, "size ro");
      apb(1'b0, 8'h7C, 32'h0);
      check({v[30:0], slv}, 32'h1, "unmapped");
      $display("test registers done");
      run(`CODE_MASS);
      em.delete();
      rd(40959);
      repeat (3) rd($urandom % 40960);
      $display("test mass erase done");
      w = $urandom % 40960;
      // at most two programs per erase
      repeat (2) begin
         prog(w, $urandom);
         rd(w);
      end
      apb(1'b0, `OFS_ADDR, 32'h0);
      check(v, w, "address");
      $display("test word program done");
      // Burst straddles a four-word boundary
      w = ((w ^ 32'h100) & 32'hFFF8) | 32'h2;
      apb(1'b1, `OFS_ADDR, w);
      for (int k = 0; k < 4; k++) begin
         d = (k == 3) ? `ONES : $urandom;
         apb(1'b1, `OFS_DAT0 + 8'(k * 4), d);
         em[w + k] = ev(w + k) & d;
      end
      run(`CODE_QUAD);
      for (int k = -1; k < 5; k++) rd(w + k);
      $display("test burst done");
      prog(w ^ 32'h200, 32'h0);
      apb(1'b1, `OFS_ADDR, w & 32'hFE00);
      apb(1'b1, `OFS_CMD, 32'h11);
      apb(1'b1, `OFS_CMD, 32'h33);
      for (int k = 0; k < 512; k++) em.delete((w & 32'hFE00) + k);
      rd(w);
      apb(1'b0, `OFS_RAW, 32'h0);
      check(v, 32'h7, "busy error");
      apb(1'b1, `OFS_RAW, 32'h7);
      rd(w & 32'hFE00);
      rd(w ^ 32'h200);
      $display("test page erase done");
      apb(1'b1, `OFS_MASK, 32'h0);
      apb(1'b1, `OFS_CMD, 32'h55);
      apb(1'b0, `OFS_STAT, 32'h0);
      check(v, 32'h0, "masked");
      apb(1'b0, `OFS_RAW, 32'h0);
      check(v, 32'h8, "illegal");
      apb(1'b1, `OFS_RAW, 32'h8);
      apb(1'b1, `OFS_MASK, 32'h3F);
      apb(1'b0, `OFS_STAT, 32'h0);
      check(v, 32'h0, "cleared");
      apb(1'b1, `OFS_CMD, 32'h100 | `CODE_PAGE);
      apb(1'b0, `OFS_RAW, 32'h0);
      check(v, 32'h8, "wide code");
      apb(1'b1, `OFS_RAW, 32'h8);
      $display("test illegal code done");
      finish_test();
   end
   initial begin
      repeat (90000) @(posedge clk);
      err_count++;
      finish_test();
   end
endmodule
